// ### hdl/timer_ccp.sv
/*
 timer prescaler, timer 0/1 count bytes and timer 2 with reload, compare,
 capture and 8-bit pwm, behind an axi4-lite slave.
 assumes the trigger pin is asynchronous; the comparator input is synchronous.
*/
// The AXI4-Lite interface to the registers was chosen for this implementation.
`timescale 1ns/1ns
module timer_ccp (
	input wire logic ref_clk,
	input wire logic nrst,
	input wire logic [11:0] s_axi_awaddr,
	input wire logic s_axi_awvalid,
	output logic s_axi_awready,
	input wire logic [31:0] s_axi_wdata,
	input wire logic [3:0] s_axi_wstrb,
	input wire logic s_axi_wvalid,
	output logic s_axi_wready,
	output logic [1:0] s_axi_bresp,
	output logic s_axi_bvalid,
	input wire logic s_axi_bready,
	input wire logic [11:0] s_axi_araddr,
	input wire logic s_axi_arvalid,
	output logic s_axi_arready,
	output logic [31:0] s_axi_rdata,
	output logic [1:0] s_axi_rresp,
	output logic s_axi_rvalid,
	input wire logic s_axi_rready,
	input wire logic timer2_external_trigger,
	input wire logic comparator_out,
	output logic timer2_compare_output,
	output logic timer0_tick,
	output logic timer1_tick
);
	// =========================================
	// registers
	logic [7:0] div_sel_q, t0l_q, t0h_q, t1l_q, t1h_q, ctl_q, mod_q, shadow_q;
	logic [15:0] cnt_q, crc_q;
	logic [7:0] div_sel_d, t0l_d, t0h_d, t1l_d, t1h_d, ctl_d, mod_d, shadow_d;
	logic [15:0] cnt_d, crc_d;
	logic cpo_q, cpo_d;
	logic [2:0] trig_q;
	logic cmp_q;
	logic aw_q, w_q, aw_d, w_d, bvalid_d, arready_d, rvalid_d;
	logic [9:0] awa_q, awa_d;
	logic [31:0] wdat_q, wdat_d, rdata_d;
	logic [1:0] bresp_d, rresp_d;
	logic t2_tick;
	logic [7:0] t2_ratio, t0_ratio, t1_ratio;

	always_comb begin
		case (div_sel_q[tmr_pkg::DIV_T2_LSB +: 3])
			3'd1: t2_ratio = tmr_pkg::DIV_2;
			3'd2: t2_ratio = tmr_pkg::DIV_4;
			3'd3: t2_ratio = tmr_pkg::DIV_8;
			3'd4: t2_ratio = tmr_pkg::DIV_12;
			3'd5: t2_ratio = tmr_pkg::DIV_16;
			3'd6: t2_ratio = tmr_pkg::DIV_32;
			3'd7: t2_ratio = tmr_pkg::DIV_128;
			default: t2_ratio = 8'h00;
		endcase
	end

	function automatic logic [7:0] small_ratio(input logic [1:0] code);
		case (code)
			2'd1: small_ratio = tmr_pkg::DIV_4;
			2'd2: small_ratio = tmr_pkg::DIV_8;
			2'd3: small_ratio = tmr_pkg::DIV_12;
			default: small_ratio = 8'h00;
		endcase
	endfunction
	assign t0_ratio = small_ratio(div_sel_q[tmr_pkg::DIV_T0_LSB +: 2]);
	assign t1_ratio = small_ratio(div_sel_q[tmr_pkg::DIV_T1_LSB +: 2]);

	tick_divider #(.WIDTH(8)) u_div2 (.ref_clk(ref_clk), .nrst(nrst), .ratio(t2_ratio),
		.tick(t2_tick));
	tick_divider #(.WIDTH(8)) u_div0 (.ref_clk(ref_clk), .nrst(nrst), .ratio(t0_ratio),
		.tick(timer0_tick));
	tick_divider #(.WIDTH(8)) u_div1 (.ref_clk(ref_clk), .nrst(nrst), .ratio(t1_ratio),
		.tick(timer1_tick));

	// =========================================
	// trigger pin: two-stage sync then edge history
	logic [1:0] sync_q;
	always_ff @(posedge ref_clk or negedge nrst) begin
		if (!nrst) begin
			sync_q <= 2'b11;
			trig_q <= 3'b111;
			cmp_q <= 1'b0;
		end else begin
			sync_q <= {sync_q[0], timer2_external_trigger};
			trig_q <= {trig_q[1:0], sync_q[1]};
			cmp_q <= comparator_out;
		end
	end
	logic fall_ev, rise_ev, cmp_rise;
	assign fall_ev = trig_q[2] & ~trig_q[1];
	assign rise_ev = ~trig_q[2] & trig_q[1];
	assign cmp_rise = comparator_out & ~cmp_q;

	// =========================================
	// axi write/read decode
	logic do_wr, do_rd;
	logic [7:0] wr_idx, rd_idx, wbyte;
	assign do_wr = aw_q & w_q & ~s_axi_bvalid;
	// awa_q holds address bits 11:2, so the index is its low byte
	assign wr_idx = awa_q[7:0];
	assign wbyte = wdat_q[7:0];
	assign do_rd = s_axi_arvalid & s_axi_arready;
	assign rd_idx = s_axi_araddr[9:2];

	function automatic logic known_idx(input logic [7:0] idx);
		case (idx)
			tmr_pkg::IDX_TIMER0_COUNT_LOW, tmr_pkg::IDX_TIMER1_COUNT_LOW,
			tmr_pkg::IDX_TIMER0_COUNT_HIGH, tmr_pkg::IDX_TIMER1_COUNT_HIGH,
			tmr_pkg::IDX_TIMER_CLOCK_DIVIDER_SELECT, tmr_pkg::IDX_TIMER2_CONTROL,
			tmr_pkg::IDX_TIMER2_MODE_REGISTER, tmr_pkg::IDX_CAPTURE_LOW,
			tmr_pkg::IDX_CAPTURE_HIGH, tmr_pkg::IDX_TIMER2_COUNT_LOW,
			tmr_pkg::IDX_TIMER2_COUNT_HIGH, tmr_pkg::IDX_COMPARE_SHADOW: known_idx = 1'b1;
			default: known_idx = 1'b0;
		endcase
	endfunction

	logic wr_ok, wr_lo, wdat_lane, wstrb_q;
	assign wr_ok = do_wr & known_idx(wr_idx) & (awa_q[9:8] == 2'b00) & wdat_lane;
	assign wr_lo = wr_ok;

	// =========================================
	// timer 2 core
	tmr_pkg::t2_mode_e mode;
	logic en, ovf, match, pwm;
	logic [1:0] edge_sel, reload_sel;
	assign mode = tmr_pkg::t2_mode_e'(mod_q[2:0]);
	assign en = ctl_q[tmr_pkg::CTL_ENABLE_BIT];
	assign edge_sel = ctl_q[tmr_pkg::CTL_EDGE_LSB +: 2];
	assign reload_sel = ctl_q[tmr_pkg::CTL_RELOAD_LSB +: 2];
	assign pwm = (mode == tmr_pkg::MODE_PWM);
	// period low byte, counter high byte
	// wrap from all ones
	// pwm restarts one count early so a cycle lasts exactly period ticks
	assign ovf = en & t2_tick & (pwm ? (({1'b0, cnt_q[15:8]} + 9'h001) >= {1'b0, cnt_q[7:0]})
		: (cnt_q == 16'hffff));
	// continuous compare
	// pwm match taken on the tick that reaches duty, keeps the ratio exact
	assign match = pwm ? (t2_tick && ((cnt_q[15:8] + 8'h01) == crc_q[7:0])) : (cnt_q == crc_q);

	logic cap_ev;
	always_comb begin
		case (edge_sel)
			2'd0: cap_ev = fall_ev;
			2'd1: cap_ev = rise_ev;
			2'd2: cap_ev = fall_ev | rise_ev;
			default: cap_ev = cmp_rise;
		endcase
	end

	always_comb begin
		div_sel_d = div_sel_q;
		t0l_d = t0l_q;
		t0h_d = t0h_q;
		t1l_d = t1l_q;
		t1h_d = t1h_q;
		ctl_d = ctl_q;
		mod_d = mod_q;
		shadow_d = shadow_q;
		cnt_d = cnt_q;
		crc_d = crc_q;
		cpo_d = cpo_q;
		if (en && t2_tick) begin
			if (pwm) begin
				cnt_d[15:8] = ovf ? 8'h00 : cnt_q[15:8] + 8'h01;
			end else begin
				cnt_d = cnt_q + 16'h0001;
			end
		end
		if (en && !pwm && reload_sel == 2'b10 && ovf) begin
			cnt_d = crc_q;
		end
		if (en && !pwm && reload_sel == 2'b11 && fall_ev) begin
			cnt_d = crc_q;
		end
		if (en && mode == tmr_pkg::MODE_CAPTURE0 && cap_ev) begin
			crc_d = cnt_q;
		end
		if (en && (mode == tmr_pkg::MODE_COMPARE_PIN || mode == tmr_pkg::MODE_COMPARE_QUIET)) begin
			if (!ctl_q[tmr_pkg::CTL_COMPARE_MODE_BIT]) begin
				// high at match, low at overflow
				if (ovf) begin
					cpo_d = 1'b0;
				end else if (match) begin
					cpo_d = 1'b1;
				end
			end else if (match) begin
				cpo_d = shadow_q[0];
			end
		end
		if (en && pwm) begin
			if (ovf) begin
				cpo_d = (edge_sel == 2'd0);
			end else if (match) begin
				cpo_d = (edge_sel != 2'd0);
			end
		end
		if (!en) begin
			cpo_d = 1'b0;
		end
		if (wr_lo) begin
			case (wr_idx)
				tmr_pkg::IDX_TIMER0_COUNT_LOW: t0l_d = wbyte;
				tmr_pkg::IDX_TIMER1_COUNT_LOW: t1l_d = wbyte;
				tmr_pkg::IDX_TIMER0_COUNT_HIGH: t0h_d = wbyte;
				tmr_pkg::IDX_TIMER1_COUNT_HIGH: t1h_d = wbyte;
				tmr_pkg::IDX_TIMER_CLOCK_DIVIDER_SELECT: div_sel_d = {1'b0, wbyte[6:0]};
				tmr_pkg::IDX_TIMER2_CONTROL: ctl_d = wbyte;
				tmr_pkg::IDX_TIMER2_MODE_REGISTER: mod_d = {5'b00000, wbyte[2:0]};
				tmr_pkg::IDX_CAPTURE_HIGH: crc_d[15:8] = wbyte;
				tmr_pkg::IDX_TIMER2_COUNT_LOW: cnt_d[7:0] = wbyte;
				tmr_pkg::IDX_TIMER2_COUNT_HIGH: cnt_d[15:8] = wbyte;
				tmr_pkg::IDX_COMPARE_SHADOW: shadow_d = {7'b0000000, wbyte[0]};
				tmr_pkg::IDX_CAPTURE_LOW: begin
					if (en && mode == tmr_pkg::MODE_CAPTURE1) begin
						crc_d = cnt_q;
					end else begin
						crc_d[7:0] = wbyte;
					end
				end
				default: begin
				end
			endcase
		end
	end

	// =========================================
	// axi channel state
	always_comb begin
		aw_d = aw_q;
		w_d = w_q;
		awa_d = awa_q;
		wdat_d = wdat_q;
		bvalid_d = s_axi_bvalid;
		bresp_d = s_axi_bresp;
		if (s_axi_awvalid && s_axi_awready) begin
			aw_d = 1'b1;
			awa_d = s_axi_awaddr[11:2] == 10'h000 ? 10'h000 : s_axi_awaddr[11:2];
		end
		if (s_axi_wvalid && s_axi_wready) begin
			w_d = 1'b1;
			wdat_d = s_axi_wdata;
		end
		if (do_wr) begin
			aw_d = 1'b0;
			w_d = 1'b0;
			bvalid_d = 1'b1;
			bresp_d = wr_ok ? tmr_pkg::RESP_OKAY : tmr_pkg::RESP_SLVERR;
		end else if (s_axi_bvalid && s_axi_bready) begin
			bvalid_d = 1'b0;
		end
		arready_d = ~s_axi_rvalid & ~do_rd;
		rvalid_d = s_axi_rvalid;
		rdata_d = s_axi_rdata;
		rresp_d = s_axi_rresp;
		if (do_rd) begin
			rvalid_d = 1'b1;
			rresp_d = (known_idx(rd_idx) && s_axi_araddr[11:10] == 2'b00) ?
				tmr_pkg::RESP_OKAY : tmr_pkg::RESP_SLVERR;
			case (rd_idx)
				tmr_pkg::IDX_TIMER0_COUNT_LOW: rdata_d = {24'h00_0000, t0l_q};
				tmr_pkg::IDX_TIMER1_COUNT_LOW: rdata_d = {24'h00_0000, t1l_q};
				tmr_pkg::IDX_TIMER0_COUNT_HIGH: rdata_d = {24'h00_0000, t0h_q};
				tmr_pkg::IDX_TIMER1_COUNT_HIGH: rdata_d = {24'h00_0000, t1h_q};
				tmr_pkg::IDX_TIMER_CLOCK_DIVIDER_SELECT: rdata_d = {24'h00_0000, div_sel_q};
				tmr_pkg::IDX_TIMER2_CONTROL: rdata_d = {24'h00_0000, ctl_q};
				tmr_pkg::IDX_TIMER2_MODE_REGISTER: rdata_d = {24'h00_0000, mod_q};
				tmr_pkg::IDX_CAPTURE_LOW: rdata_d = {24'h00_0000, crc_q[7:0]};
				tmr_pkg::IDX_CAPTURE_HIGH: rdata_d = {24'h00_0000, crc_q[15:8]};
				tmr_pkg::IDX_TIMER2_COUNT_LOW: rdata_d = {24'h00_0000, cnt_q[7:0]};
				tmr_pkg::IDX_TIMER2_COUNT_HIGH: rdata_d = {24'h00_0000, cnt_q[15:8]};
				tmr_pkg::IDX_COMPARE_SHADOW: rdata_d = {24'h00_0000, shadow_q};
				default: rdata_d = 32'h0000_0000;
			endcase
		end else if (s_axi_rvalid && s_axi_rready) begin
			rvalid_d = 1'b0;
		end
	end
	// byte lane 0 must be strobed for a register write to land
	assign wdat_lane = wstrb_q;
	always_ff @(posedge ref_clk or negedge nrst) begin
		if (!nrst) begin
			wstrb_q <= 1'b0;
		end else if (s_axi_wvalid && s_axi_wready) begin
			wstrb_q <= s_axi_wstrb[0];
		end
	end

	always_ff @(posedge ref_clk or negedge nrst) begin
		if (!nrst) begin
			div_sel_q <= tmr_pkg::RST_DIVIDER_SELECT;
			t0l_q <= tmr_pkg::RST_BYTE;
			t0h_q <= tmr_pkg::RST_BYTE;
			t1l_q <= tmr_pkg::RST_BYTE;
			t1h_q <= tmr_pkg::RST_BYTE;
			ctl_q <= tmr_pkg::RST_BYTE;
			mod_q <= tmr_pkg::RST_BYTE;
			shadow_q <= tmr_pkg::RST_BYTE;
			cnt_q <= 16'h0000;
			crc_q <= 16'h0000;
			cpo_q <= 1'b0;
			timer2_compare_output <= 1'b0;
			aw_q <= 1'b0;
			w_q <= 1'b0;
			awa_q <= 10'h000;
			wdat_q <= 32'h0000_0000;
			s_axi_bvalid <= 1'b0;
			s_axi_bresp <= tmr_pkg::RESP_OKAY;
			s_axi_arready <= 1'b0;
			s_axi_rvalid <= 1'b0;
			s_axi_rdata <= 32'h0000_0000;
			s_axi_rresp <= tmr_pkg::RESP_OKAY;
			s_axi_awready <= 1'b0;
			s_axi_wready <= 1'b0;
		end else begin
			div_sel_q <= div_sel_d;
			t0l_q <= t0l_d;
			t0h_q <= t0h_d;
			t1l_q <= t1l_d;
			t1h_q <= t1h_d;
			ctl_q <= ctl_d;
			mod_q <= mod_d;
			shadow_q <= shadow_d;
			cnt_q <= cnt_d;
			crc_q <= crc_d;
			cpo_q <= cpo_d;
			// quiet compare mode keeps the pin low
			timer2_compare_output <= cpo_d & (mode != tmr_pkg::MODE_COMPARE_QUIET);
			aw_q <= aw_d;
			w_q <= w_d;
			awa_q <= awa_d;
			wdat_q <= wdat_d;
			s_axi_bvalid <= bvalid_d;
			s_axi_bresp <= bresp_d;
			s_axi_arready <= arready_d;
			s_axi_rvalid <= rvalid_d;
			s_axi_rdata <= rdata_d;
			s_axi_rresp <= rresp_d;
			s_axi_awready <= ~aw_d;
			s_axi_wready <= ~w_d;
		end
	end

	// =========================================
	// checks
	// wrap yields zero count
	AST_WRAP: assert property (@(posedge ref_clk) disable iff (!nrst)
		(ovf && !pwm && reload_sel[1] == 1'b0 && !wr_lo) |=> cnt_q == 16'h0000)
		else $error("timer 2 did not wrap to zero");
	AST_RELOAD0: assert property (@(posedge ref_clk) disable iff (!nrst)
		(ovf && !pwm && reload_sel == 2'b10 && !wr_lo) |=> cnt_q == $past(crc_q))
		else $error("overflow reload missed");
	AST_RELOAD1: assert property (@(posedge ref_clk) disable iff (!nrst)
		(en && fall_ev && !pwm && reload_sel == 2'b11 && !wr_lo) |=> cnt_q == $past(crc_q))
		else $error("trigger reload missed");
	AST_HOLD: assert property (@(posedge ref_clk) disable iff (!nrst)
		(!en && !wr_lo) |=> $stable(cnt_q) && !cpo_q)
		else $error("disabled timer changed");
	AST_CMP0: assert property (@(posedge ref_clk) disable iff (!nrst)
		(en && mode == tmr_pkg::MODE_COMPARE_PIN && !ctl_q[2] && match && !ovf && !wr_lo)
		|=> timer2_compare_output)
		else $error("compare mode 0 output not set");
	AST_CMP1: assert property (@(posedge ref_clk) disable iff (!nrst)
		(en && mode == tmr_pkg::MODE_COMPARE_PIN && ctl_q[2] && match && !wr_lo)
		|=> cpo_q == $past(shadow_q[0]))
		else $error("shadow level not copied");
	AST_PWM_RESTART: assert property (@(posedge ref_clk) disable iff (!nrst)
		(ovf && pwm && !wr_lo) |=> cnt_q[15:8] == 8'h00)
		else $error("pwm counter did not restart");
	AST_CAP1: assert property (@(posedge ref_clk) disable iff (!nrst)
		(wr_lo && wr_idx == tmr_pkg::IDX_CAPTURE_LOW && en && mode == tmr_pkg::MODE_CAPTURE1)
		|=> crc_q == $past(cnt_q))
		else $error("software capture missed");
	AST_CAP0: assert property (@(posedge ref_clk) disable iff (!nrst)
		(en && mode == tmr_pkg::MODE_CAPTURE0 && cap_ev && !wr_lo) |=> crc_q == $past(cnt_q))
		else $error("edge capture missed");
endmodule

// ### hdl/tmr_pkg.sv
/*
 timer block package: register offsets, field positions, reset values, enums.
 assumes a 32-bit axi4-lite slave where each register takes one aligned word.
*/
package tmr_pkg;
	// =========================================
	// register map (byte index; byte address = index * 4)
	localparam logic [7:0] IDX_TIMER0_COUNT_LOW = 8'h8a;
	localparam logic [7:0] IDX_TIMER1_COUNT_LOW = 8'h8b;
	localparam logic [7:0] IDX_TIMER0_COUNT_HIGH = 8'h8c;
	localparam logic [7:0] IDX_TIMER1_COUNT_HIGH = 8'h8d;
	localparam logic [7:0] IDX_TIMER_CLOCK_DIVIDER_SELECT = 8'h8f;
	localparam logic [7:0] IDX_TIMER2_CONTROL = 8'hc8;
	localparam logic [7:0] IDX_TIMER2_MODE_REGISTER = 8'hc9;
	localparam logic [7:0] IDX_CAPTURE_LOW = 8'hca;
	localparam logic [7:0] IDX_CAPTURE_HIGH = 8'hcb;
	localparam logic [7:0] IDX_TIMER2_COUNT_LOW = 8'hcc;
	localparam logic [7:0] IDX_TIMER2_COUNT_HIGH = 8'hcd;
	localparam logic [7:0] IDX_COMPARE_SHADOW = 8'hce;
	// =========================================
	// reset values
	localparam logic [7:0] RST_DIVIDER_SELECT = 8'h4f;
	localparam logic [7:0] RST_BYTE = 8'h00;
	// =========================================
	// field positions
	localparam int CTL_ENABLE_BIT = 7;
	localparam int CTL_EDGE_LSB = 5;
	localparam int CTL_RELOAD_LSB = 3;
	localparam int CTL_COMPARE_MODE_BIT = 2;
	localparam int DIV_T2_LSB = 4;
	localparam int DIV_T1_LSB = 2;
	localparam int DIV_T0_LSB = 0;
	// =========================================
	// divide ratios
	localparam logic [7:0] DIV_2 = 8'h02;
	localparam logic [7:0] DIV_4 = 8'h04;
	localparam logic [7:0] DIV_8 = 8'h08;
	localparam logic [7:0] DIV_12 = 8'h0c;
	localparam logic [7:0] DIV_16 = 8'h10;
	localparam logic [7:0] DIV_32 = 8'h20;
	localparam logic [7:0] DIV_128 = 8'h80;
	// =========================================
	// axi responses
	localparam logic [1:0] RESP_OKAY = 2'h0;
	localparam logic [1:0] RESP_SLVERR = 2'h2;

	typedef enum logic [2:0] {
		MODE_TIMER,
		MODE_CAPTURE0,
		MODE_CAPTURE1,
		MODE_COMPARE_QUIET,
		MODE_COMPARE_PIN,
		MODE_PWM,
		MODE_TIMER_B,
		MODE_TIMER_C
	} t2_mode_e;
endpackage

// ### hdl/tick_divider.sv
/*
 one-cycle tick divider: pulses tick every ratio cycles while ratio is nonzero.
 assumes ratio comes from a register on the same clock.
*/
`timescale 1ns/1ns
module tick_divider #(
	parameter int WIDTH = 8
) (
	input wire logic ref_clk,
	input wire logic nrst,
	input wire logic [WIDTH-1:0] ratio,
	output logic tick
);
	logic [WIDTH-1:0] cnt_q, cnt_d;
	logic tick_d;

	// ratio zero (reserved code) stalls the tick
	always_comb begin
		cnt_d = cnt_q;
		tick_d = 1'b0;
		if (ratio != '0) begin
			if (cnt_q >= ratio - 1'b1) begin
				cnt_d = '0;
				tick_d = 1'b1;
			end else begin
				cnt_d = cnt_q + 1'b1;
			end
		end else begin
			cnt_d = '0;
		end
	end

	always_ff @(posedge ref_clk or negedge nrst) begin
		if (!nrst) begin
			cnt_q <= '0;
			tick <= 1'b0;
		end else begin
			cnt_q <= cnt_d;
			tick <= tick_d;
		end
	end
endmodule

// ### tb/pin_partner.sv
/*
 far side of the timer pins: trigger pin and comparator level.
 assumes tasks are called just after a rising clock edge.
*/
`timescale 1ns/1ns
module pin_partner (
	input wire logic ref_clk,
	output logic trig,
	output logic cmp
);
	// =========================================
	// pin drive
	// idle high so the first move is a clean fall
	initial begin
		trig = 1'b1;
		cmp = 1'b0;
	end
	// hold 8 cycles: covers the two-stage synchroniser
	task automatic set_trig(input logic lvl);
		trig <= lvl;
		repeat (8) @(posedge ref_clk);
	endtask
	task automatic set_cmp(input logic lvl);
		cmp <= lvl;
		repeat (8) @(posedge ref_clk);
	endtask
endmodule

// ### tb/timer_ccp_tb.sv
/*
 self-checking bench for timer_ccp over axi4-lite, with pin_partner.
 assumes reads and writes never overlap; the bench is the only master.
*/
`timescale 1ns/1ns
module timer_ccp_tb;
	localparam logic [7:0] CTL = tmr_pkg::IDX_TIMER2_CONTROL;
	localparam logic [7:0] MDR = tmr_pkg::IDX_TIMER2_MODE_REGISTER;
	localparam logic [7:0] DIV = tmr_pkg::IDX_TIMER_CLOCK_DIVIDER_SELECT;
	localparam logic [7:0] CPL = tmr_pkg::IDX_CAPTURE_LOW;
	localparam logic [7:0] CPH = tmr_pkg::IDX_CAPTURE_HIGH;
	localparam logic [7:0] CNL = tmr_pkg::IDX_TIMER2_COUNT_LOW;
	localparam logic [7:0] CNH = tmr_pkg::IDX_TIMER2_COUNT_HIGH;
	localparam logic [7:0] SHD = tmr_pkg::IDX_COMPARE_SHADOW;
	localparam logic [1:0] OK = tmr_pkg::RESP_OKAY;
	localparam logic [1:0] ERR = tmr_pkg::RESP_SLVERR;
	logic ref_clk = 1'b0;
	logic nrst = 1'b0;
	logic [11:0] s_axi_awaddr = 12'h000;
	logic s_axi_awvalid = 1'b0;
	logic s_axi_awready;
	logic [31:0] s_axi_wdata = 32'h0000_0000;
	logic [3:0] s_axi_wstrb = 4'hf;
	logic s_axi_wvalid = 1'b0;
	logic s_axi_wready;
	logic [1:0] s_axi_bresp;
	logic s_axi_bvalid;
	logic s_axi_bready = 1'b0;
	logic [11:0] s_axi_araddr = 12'h000;
	logic s_axi_arvalid = 1'b0;
	logic s_axi_arready;
	logic [31:0] s_axi_rdata;
	logic [1:0] s_axi_rresp;
	logic s_axi_rvalid;
	logic s_axi_rready = 1'b0;
	logic trig;
	logic cmp;
	logic timer2_compare_output;
	logic timer0_tick;
	logic timer1_tick;
	logic [33:0] exp_q[$];
	int fail_count = 0;
	int num_checks = 0;
	int cyc = 0;

	timer_ccp timer_ccp_inst (.ref_clk(ref_clk), .nrst(nrst), .s_axi_awaddr(s_axi_awaddr),
		.s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready),
		.s_axi_wdata(s_axi_wdata), .s_axi_wstrb(s_axi_wstrb), .s_axi_wvalid(s_axi_wvalid),
		.s_axi_wready(s_axi_wready), .s_axi_bresp(s_axi_bresp), .s_axi_bvalid(s_axi_bvalid),
		.s_axi_bready(s_axi_bready), .s_axi_araddr(s_axi_araddr),
		.s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready),
		.s_axi_rdata(s_axi_rdata), .s_axi_rresp(s_axi_rresp), .s_axi_rvalid(s_axi_rvalid),
		.s_axi_rready(s_axi_rready), .timer2_external_trigger(trig), .comparator_out(cmp),
		.timer2_compare_output(timer2_compare_output), .timer0_tick(timer0_tick),
		.timer1_tick(timer1_tick));
	pin_partner pin_partner_inst (.ref_clk(ref_clk), .trig(trig), .cmp(cmp));

	always #4 ref_clk = ~ref_clk;

	// =========================================
	// checking and closing
	task automatic check(input logic [33:0] seen, input logic [33:0] exp);
		num_checks++;
		if (seen !== exp) begin
			fail_count++;
			$display("FAIL t=%0t seen=%h exp=%h", $time, seen, exp);
		end
	endtask
	task automatic results();
		$display("checks=%0d mismatches=%0d", num_checks, fail_count);
		if (fail_count == 0 && num_checks > 0) begin
			$display("STATUS OK");
		end else begin
			$display("STATUS NOT OK");
		end
		$finish;
	endtask
	// ceiling: capture section must finish before count high byte moves
	always @(posedge ref_clk) begin
		cyc++;
		if (cyc == 30000) begin
			fail_count++;
			results();
		end
	end
	always @(posedge ref_clk) begin
		if (s_axi_rvalid === 1'b1 && s_axi_rready === 1'b1) begin
			check({s_axi_rresp, s_axi_rdata}, exp_q.pop_front());
		end
	end

	// =========================================
	// bus tasks
	task automatic wr(input logic [7:0] idx, input logic [7:0] val, input logic [1:0] resp);
		logic aw_done;
		logic w_done;
		aw_done = 1'b0;
		w_done = 1'b0;
		s_axi_awaddr <= {2'b00, idx, 2'b00};
		s_axi_wdata <= {24'h00_0000, val};
		s_axi_awvalid <= 1'b1;
		s_axi_wvalid <= 1'b1;
		s_axi_bready <= 1'b1;
		while (!(aw_done && w_done)) begin
			@(posedge ref_clk);
			if (!aw_done && s_axi_awready === 1'b1) begin
				aw_done = 1'b1;
				s_axi_awvalid <= 1'b0;
			end
			if (!w_done && s_axi_wready === 1'b1) begin
				w_done = 1'b1;
				s_axi_wvalid <= 1'b0;
			end
		end
		do @(posedge ref_clk); while (s_axi_bvalid !== 1'b1);
		s_axi_bready <= 1'b0;
		check({32'h0000_0000, s_axi_bresp}, {32'h0000_0000, resp});
		@(posedge ref_clk);
	endtask
	task automatic rd(input logic [7:0] idx, input logic [7:0] val, input logic [1:0] resp);
		exp_q.push_back({resp, 24'h00_0000, val});
		s_axi_araddr <= {2'b00, idx, 2'b00};
		s_axi_arvalid <= 1'b1;
		s_axi_rready <= 1'b1;
		do @(posedge ref_clk); while (s_axi_arready !== 1'b1);
		s_axi_arvalid <= 1'b0;
		do @(posedge ref_clk); while (s_axi_rvalid !== 1'b1);
		s_axi_rready <= 1'b0;
		@(posedge ref_clk);
	endtask
	task automatic gap(input logic sel, output int n);
		n = 0;
		do @(posedge ref_clk); while ((sel ? timer1_tick : timer0_tick) !== 1'b1);
		do begin
			@(posedge ref_clk);
			n++;
		end while ((sel ? timer1_tick : timer0_tick) !== 1'b1);
	endtask
	task automatic width(input logic lvl, output int n);
		n = 0;
		// no extra edge here: back-to-back calls measure a whole run
		while (timer2_compare_output !== lvl) begin
			@(posedge ref_clk);
		end
		while (timer2_compare_output === lvl) begin
			@(posedge ref_clk);
			n++;
		end
	endtask
	task automatic setup(input logic [7:0] dv, input logic [15:0] cnt, input logic [15:0] cc,
			input tmr_pkg::t2_mode_e md);
		wr(CTL, 8'h00, OK);
		wr(DIV, dv, OK);
		wr(CNL, cnt[7:0], OK);
		wr(CNH, cnt[15:8], OK);
		wr(CPL, cc[7:0], OK);
		wr(CPH, cc[15:8], OK);
		wr(MDR, 8'(md), OK);
	endtask

	// =========================================
	// main sequence
	initial begin
		int n;
		int dv[7];
		int tdv[3];
		logic [7:0] rv;
		logic [7:0] cregs[4];
		logic [7:0] rctl[3];
		logic [7:0] rexp[3];
		dv = '{2, 4, 8, 12, 16, 32, 128};
		tdv = '{4, 8, 12};
		cregs = '{tmr_pkg::IDX_TIMER0_COUNT_LOW, tmr_pkg::IDX_TIMER1_COUNT_LOW,
			tmr_pkg::IDX_TIMER0_COUNT_HIGH, tmr_pkg::IDX_TIMER1_COUNT_HIGH};
		rctl = '{8'h90, 8'h80, 8'h98};
		rexp = '{8'hff, 8'h00, 8'h00};
		void'($urandom(32'h3349));
		repeat (5) @(posedge ref_clk);
		nrst <= 1'b1;
		@(posedge ref_clk);
		rd(DIV, tmr_pkg::RST_DIVIDER_SELECT, OK);
		rd(8'h00, 8'h00, ERR);
		wr(8'h00, 8'h5a, ERR);
		foreach (cregs[i]) begin
			rd(cregs[i], tmr_pkg::RST_BYTE, OK);
			rv = 8'($urandom());
			wr(cregs[i], rv, OK);
			rd(cregs[i], rv, OK);
		end
		// lane 0 not strobed: refused, register keeps its value
		s_axi_wstrb <= 4'he;
		wr(cregs[3], ~rv, ERR);
		s_axi_wstrb <= 4'hf;
		rd(cregs[3], rv, OK);
		for (int c = 1; c < 4; c++) begin
			wr(DIV, 8'h40 | 8'(c * 5), OK);
			gap(1'b0, n);
			check(34'(n), 34'(tdv[c - 1]));
			gap(1'b1, n);
			check(34'(n), 34'(tdv[c - 1]));
		end
		// high from match at fff8 to wrap: 8 ticks less the registered cycle
		for (int c = 1; c < 8; c++) begin
			setup(8'(c << 4) | 8'h0f, 16'hfff0, 16'hfff8, tmr_pkg::MODE_COMPARE_PIN);
			wr(CTL, 8'h80, OK);
			width(1'b1, n);
			check(34'(n), 34'(dv[c - 1] * 8 - 1));
		end
		setup(8'h1f, 16'hfff0, 16'hfff8, tmr_pkg::MODE_COMPARE_PIN);
		wr(SHD, 8'h01, OK);
		wr(CTL, 8'h84, OK);
		repeat (60) @(posedge ref_clk);
		check({33'h0, timer2_compare_output}, 34'h1);
		wr(MDR, 8'(tmr_pkg::MODE_COMPARE_QUIET), OK);
		repeat (2) @(posedge ref_clk);
		check({33'h0, timer2_compare_output}, 34'h0);
		wr(MDR, 8'(tmr_pkg::MODE_COMPARE_PIN), OK);
		repeat (2) @(posedge ref_clk);
		check({33'h0, timer2_compare_output}, 34'h1);
		wr(CTL, 8'h04, OK);
		repeat (2) @(posedge ref_clk);
		check({33'h0, timer2_compare_output}, 34'h0);
		foreach (rctl[i]) begin
			setup(8'h1f, 16'hfffe, 16'hff00, tmr_pkg::MODE_TIMER);
			wr(CTL, rctl[i], OK);
			repeat (20) @(posedge ref_clk);
			rd(CNH, rexp[i], OK);
		end
		pin_partner_inst.set_trig(1'b0);
		rd(CNH, 8'hff, OK);
		pin_partner_inst.set_trig(1'b1);
		// count high byte holds 56 for 32768 cycles at /128
		setup(8'h7f, 16'h5600, 16'h0000, tmr_pkg::MODE_CAPTURE0);
		for (int e = 0; e < 3; e++) begin
			wr(CTL, 8'h80 | 8'(e << 5), OK);
			wr(CPH, 8'h00, OK);
			pin_partner_inst.set_trig(1'b0);
			rd(CPH, (e == 1) ? 8'h00 : 8'h56, OK);
			pin_partner_inst.set_trig(1'b1);
			rd(CPH, 8'h56, OK);
		end
		wr(CTL, 8'he0, OK);
		wr(CPH, 8'h00, OK);
		pin_partner_inst.set_cmp(1'b1);
		rd(CPH, 8'h56, OK);
		pin_partner_inst.set_cmp(1'b0);
		wr(MDR, 8'(tmr_pkg::MODE_CAPTURE1), OK);
		wr(CPH, 8'h00, OK);
		wr(CPL, 8'ha5, OK);
		rd(CPH, 8'h56, OK);
		setup(8'h1f, 16'h000a, 16'h0004, tmr_pkg::MODE_PWM);
		wr(CTL, 8'h80, OK);
		width(1'b0, n);
		width(1'b1, n);
		check(34'(n), 34'd8);
		width(1'b0, n);
		check(34'(n), 34'd12);
		wr(CTL, 8'ha0, OK);
		width(1'b1, n);
		width(1'b0, n);
		check(34'(n), 34'd8);
		results();
	end
endmodule
